// ### clie_engine.sv
// Purpose: instruction interpreter of a character display controller behind AXI4-Lite
// Assumes: writes to CMD carry an instruction (register select low), DATA carries RAM data
// Notes: in 4-bit mode each byte arrives as two writes, high nibble first, in bits 7:4
//
// Functional notes
// R1: clear fills text ram with spaces, home
// R2: clear forces entry direction increment
// R3: home zeroes counter and shift only
// R4: ram access steps counter by direction
// R5: display shifts only on text writes
// R6: display bit blanks panel, keeps data
// R7: cursor bit shows cursor, keeps direction
// R8: blink alternates cursor cell with block
// R9: shift command moves cursor or display
// R10: display shift keeps counter, all lines
// R11: two-line cursor wraps into second line
// R12: bus width bit picks 8/4-bit transfers
// R13: line bit picks one or two lines
// R14: font bit picks 5x8 or 5x11
// R15: glyph address set loads six bits
// R16: text address set loads seven bits
// R17: text address range follows line mode
// R18: status read gives busy and counter
// R19: host waits busy low before commands
// R20: data write stores, then counter steps
// R21: first read after write is stale
// R22: cursor shift preloads read register; the code preloads it only while text ram is selected, not glyph ram
// R23: high nibble travels first
// R24: busy held for execution time
// R25: next instruction after busy drops
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module clie_engine
	import clie_pkg::*;
#(
	parameter int unsigned LONG_CYCLES = LONG_CYC,
	parameter int unsigned BLINK_DIV   = 12
)(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             panel_enable,
	output logic             cursor_visible,
	output logic [6:0]       cursor_addr,
	output logic [6:0]       view_offset
);
	initial
	begin
		if (LONG_CYCLES < CMD_CYC || LONG_CYCLES > 2097152 || BLINK_DIV < 1 || BLINK_DIV > 29)
			$error("clie_engine: bad parameter");
	end

	logic [7:0]  text_ram [TEXT_DEPTH];
	logic [7:0]  glyph_ram [GLYPH_DEPTH];
	clie_mode_t  mode_reg;
	clie_state_t state_reg;
	logic [6:0]  address_counter;
	logic        glyph_sel_reg;
	logic [6:0]  shift_reg;
	logic [7:0]  out_data_reg;
	logic [20:0] busy_cnt_reg;
	logic [6:0]  clr_idx_reg;
	logic        nib_pend_reg;
	logic [3:0]  nib_hi_reg;
	logic        nib_rd_reg;
	logic [29:0] blink_cnt_reg;
	logic        busy_indicator;
	assign busy_indicator = (state_reg != CLIE_IDLE);

	// R11: carry into second line
	// R17: wrap follows line mode
	function automatic logic [6:0] clie_step(input logic [6:0] a, input logic up, input logic two, input logic glyph);
		logic [6:0] r;
		r = up ? a + 7'd1 : a - 7'd1;
		if (glyph)
			r = {1'b0, r[5:0]};
		else if (!two)
		begin
			if (up && a == ONE_LINE_LAST)
				r = ADDR_HOME;
			else if (!up && a == ADDR_HOME)
				r = ONE_LINE_LAST;
		end
		else
		begin
			if (up && a == LINE1_LAST)
				r = LINE2_FIRST;
			else if (up && a == LINE2_LAST)
				r = ADDR_HOME;
			else if (!up && a == LINE2_FIRST)
				r = LINE1_LAST;
			else if (!up && a == ADDR_HOME)
				r = LINE2_LAST;
		end
		return r;
	endfunction

	function automatic logic [6:0] clie_rot(input logic [6:0] s, input logic left, input logic two);
		logic [6:0] w;
		logic [6:0] r;
		w = two ? SHIFT_WRAP : SHIFT_WRAP1;
		if (left)
			r = (s == w - 7'd1) ? 7'd0 : s + 7'd1;
		else
			r = (s == 7'd0) ? w - 7'd1 : s - 7'd1;
		return r;
	endfunction

	// bus slave: both address and data must be held before a write is taken
	logic       aw_held, w_held;
	logic [3:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic       wr_go;
	logic [3:0] rd_addr;
	logic       rd_go;
	assign wr_go   = aw_held && w_held && !s_axi_bvalid;
	assign rd_addr = s_axi_araddr;
	assign rd_go   = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr_reg   <= 4'h0;
			w_data_reg    <= 8'h00;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held     <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held     <= 1'b1;
				w_data_reg <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (wr_go)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg == OFS_CMD || aw_addr_reg == OFS_DATA) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// nibble assembly: a full byte is ready on the second half in 4-bit mode
	logic       wr_cmd, wr_dat, byte_done;
	logic [7:0] wr_byte;
	// R12: bus width steering
	// R23: high nibble first
	assign byte_done = wr_go && (aw_addr_reg == OFS_CMD || aw_addr_reg == OFS_DATA) && (mode_reg.wide_bus || nib_pend_reg);
	assign wr_byte   = mode_reg.wide_bus ? w_data_reg : {nib_hi_reg, w_data_reg[7:4]};
	// R25: instructions during busy ignored
	assign wr_cmd    = byte_done && aw_addr_reg == OFS_CMD && !busy_indicator;
	assign wr_dat    = byte_done && aw_addr_reg == OFS_DATA && !busy_indicator;

	// read data register access also counts as a ram access
	logic rd_dat;
	assign rd_dat = rd_go && rd_addr == OFS_DATA && !busy_indicator && (mode_reg.wide_bus || nib_rd_reg);
	logic [6:0] next_addr;
	assign next_addr = clie_step(address_counter, mode_reg.inc, mode_reg.two_line, glyph_sel_reg);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			nib_pend_reg <= 1'b0;
			nib_hi_reg   <= 4'h0;
			nib_rd_reg   <= 1'b0;
		end
		else
		begin
			if (wr_go && (aw_addr_reg == OFS_CMD || aw_addr_reg == OFS_DATA) && !mode_reg.wide_bus)
			begin
				nib_pend_reg <= !nib_pend_reg;
				nib_hi_reg   <= w_data_reg[7:4];
			end
			if (rd_go && !mode_reg.wide_bus && (rd_addr == OFS_DATA || rd_addr == OFS_STATUS))
				nib_rd_reg <= !nib_rd_reg;
		end
	end

	// instruction execution
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg       <= CLIE_IDLE;
			mode_reg        <= '{inc: 1'b1, wide_bus: 1'b1, default: 1'b0};
			address_counter <= ADDR_HOME;
			glyph_sel_reg   <= 1'b0;
			shift_reg       <= 7'd0;
			out_data_reg    <= 8'h00;
			busy_cnt_reg    <= 21'd0;
			clr_idx_reg     <= 7'd0;
		end
		else
		begin
			case (state_reg)
				CLIE_IDLE:
				begin
					if (wr_cmd)
					begin
						state_reg    <= CLIE_EXEC;
						busy_cnt_reg <= 21'(CMD_CYC - 1);
						if (wr_byte[7])
						begin
							// R16: text address set
							address_counter <= wr_byte[6:0];
							glyph_sel_reg   <= 1'b0;
							out_data_reg    <= text_ram[wr_byte[6:0]];
						end
						else if (wr_byte[6])
						begin
							// R15: glyph address set
							address_counter <= {1'b0, wr_byte[5:0]};
							glyph_sel_reg   <= 1'b1;
							out_data_reg    <= glyph_ram[wr_byte[5:0]];
						end
						else if (wr_byte[5])
						begin
							// R12: function set width
							// R13: line count
							// R14: font cell
							mode_reg.wide_bus  <= wr_byte[4];
							mode_reg.two_line  <= wr_byte[3];
							mode_reg.tall_font <= wr_byte[2];
						end
						else if (wr_byte[4])
						begin
							if (!wr_byte[3])
							begin
								// R9: cursor move steps counter
								// R22: shift preloads output register
								address_counter <= clie_step(address_counter, wr_byte[2], mode_reg.two_line, glyph_sel_reg);
								if (!glyph_sel_reg)
									out_data_reg <= text_ram[clie_step(address_counter, wr_byte[2], mode_reg.two_line, 1'b0)];
							end
							else
								// R10: display shift keeps counter
								shift_reg <= clie_rot(shift_reg, !wr_byte[2], mode_reg.two_line);
						end
						else if (wr_byte[3])
						begin
							// R6: display on bit
							// R7: cursor bit only
							// R8: blink bit
							mode_reg.disp_on   <= wr_byte[2];
							mode_reg.cursor_on <= wr_byte[1];
							mode_reg.blink_on  <= wr_byte[0];
						end
						else if (wr_byte[2])
						begin
							mode_reg.inc         <= wr_byte[1];
							mode_reg.shift_entry <= wr_byte[0];
						end
						else if (wr_byte[1])
						begin
							// R3: home, data untouched
							address_counter <= ADDR_HOME;
							glyph_sel_reg   <= 1'b0;
							shift_reg       <= 7'd0;
							busy_cnt_reg    <= 21'(LONG_CYCLES - 1);
						end
						else if (wr_byte[0])
						begin
							// R1: clear walks every text cell
							// R2: direction forced to increment
							address_counter <= ADDR_HOME;
							glyph_sel_reg   <= 1'b0;
							shift_reg       <= 7'd0;
							mode_reg.inc    <= 1'b1;
							clr_idx_reg     <= 7'd0;
							state_reg       <= CLIE_CLEAR;
							busy_cnt_reg    <= 21'(LONG_CYCLES - 1);
						end
					end
					else if (wr_dat || rd_dat)
					begin
						// R20: store then step
						// R4: step by entry direction
						// R5: shift only on text writes
						state_reg       <= CLIE_EXEC;
						busy_cnt_reg    <= 21'(DATA_CYC - 1);
						address_counter <= next_addr;
						if (wr_dat && !glyph_sel_reg && mode_reg.shift_entry)
							shift_reg <= clie_rot(shift_reg, mode_reg.inc, mode_reg.two_line);
						// R21: read register refilled only after read
						if (rd_dat)
							out_data_reg <= glyph_sel_reg ? glyph_ram[next_addr[5:0]] : text_ram[next_addr];
					end
				end
				CLIE_CLEAR:
				begin
					clr_idx_reg  <= clr_idx_reg + 7'd1;
					busy_cnt_reg <= busy_cnt_reg - 21'd1;
					if (clr_idx_reg == 7'(TEXT_DEPTH - 1))
						state_reg <= CLIE_EXEC;
				end
				CLIE_EXEC:
				begin
					// R24: busy for execution time
					busy_cnt_reg <= busy_cnt_reg - 21'd1;
					if (busy_cnt_reg == 21'd0)
						state_reg <= CLIE_IDLE;
				end
				default: state_reg <= CLIE_IDLE;
			endcase
		end
	end

	// ram storage; no reset on arrays
	always_ff @(posedge aclk)
	begin
		if (state_reg == CLIE_CLEAR)
			text_ram[clr_idx_reg] <= SPACE_CODE;
		else if (state_reg == CLIE_IDLE && wr_dat && !glyph_sel_reg)
			text_ram[address_counter] <= wr_byte;
		if (state_reg == CLIE_IDLE && wr_dat && glyph_sel_reg)
			glyph_ram[address_counter[5:0]] <= wr_byte;
	end

	// read answer, one cycle after acceptance
	logic [7:0] rd_byte;
	always_comb
	begin
		rd_byte = 8'h00;
		case (rd_addr)
			// R18: busy on top bit
			OFS_STATUS: rd_byte = {busy_indicator, address_counter};
			OFS_DATA:   rd_byte = out_data_reg;
			default:    rd_byte = 8'h00;
		endcase
		if (!mode_reg.wide_bus && (rd_addr == OFS_DATA || rd_addr == OFS_STATUS))
			rd_byte = nib_rd_reg ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (rd_addr == OFS_CMD) ? RESP_SLVERR : RESP_OKAY;
				if (rd_addr == OFS_MODE)
					s_axi_rdata <= {22'h0, nib_rd_reg, glyph_sel_reg, mode_reg[0], mode_reg[1], mode_reg[2],
						mode_reg[3], mode_reg[4], mode_reg[5], mode_reg[6], mode_reg[7]};
				else
					s_axi_rdata <= {24'h0, rd_byte};
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// panel side outputs; blink phase from a free divider
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			blink_cnt_reg  <= 30'd0;
			panel_enable   <= 1'b0;
			cursor_visible <= 1'b0;
			cursor_addr    <= ADDR_HOME;
			view_offset    <= 7'd0;
		end
		else
		begin
			blink_cnt_reg  <= blink_cnt_reg + 30'd1;
			panel_enable   <= mode_reg.disp_on;
			// R8: blink phase toggles the cell
			cursor_visible <= mode_reg.disp_on && (mode_reg.cursor_on || (mode_reg.blink_on && blink_cnt_reg[BLINK_DIV]));
			cursor_addr    <= address_counter;
			view_offset    <= shift_reg;
		end
	end

	// R24: busy span bounded by count
	busy_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == CLIE_EXEC && busy_cnt_reg == 21'd0) |=> !busy_indicator) // R24
		else $error("busy did not drop at end of count");
	cmd_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && !wr_byte[7] && !wr_byte[6] && wr_byte[5]) |=> busy_indicator [*8]) // R24
		else $error("command busy too short");
	clear_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && wr_byte == 8'h01) |=> (mode_reg.inc && address_counter == ADDR_HOME && state_reg == CLIE_CLEAR)) // R2
		else $error("clear did not home and increment");
	home_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && wr_byte[7:1] == 7'h01) |=> (shift_reg == 7'd0 && address_counter == ADDR_HOME)) // R3
		else $error("home left a shift");
	disp_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && wr_byte[7:3] == 5'b00011) |=> $stable(address_counter)) // R10
		else $error("display shift moved counter");
	read_noshift_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_dat && state_reg == CLIE_IDLE && !wr_cmd && !wr_dat) |=> $stable(shift_reg)) // R5
		else $error("read shifted display");
	line_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_dat && state_reg == CLIE_IDLE && mode_reg.two_line && mode_reg.inc && !glyph_sel_reg
			&& address_counter == LINE1_LAST) |=> address_counter == LINE2_FIRST) // R11
		else $error("no carry into second line");
	text_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && wr_byte[7]) |=> (address_counter == $past(wr_byte[6:0]) && !glyph_sel_reg)) // R16
		else $error("text address not loaded");
endmodule
`default_nettype wire

// ### clie_engine_test.sv
// Purpose: self-checking bench for the display instruction engine
// Assumes: clear and home shortened to 975 cycles, blink on a short divider
// Notes: a monitor pairs each bus answer with the oldest noted expectation
`timescale 1ns/1ps
`default_nettype none
module clie_engine_test
	import clie_pkg::*;
;
	localparam int unsigned LIMIT = 100000;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, saw;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, panel_enable, cursor_visible;
	logic [6:0]  cursor_addr, view_offset;
	logic [7:0]  rb, rc;
	int          failures = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #20 aclk = ~aclk;

	clie_engine #(.LONG_CYCLES(975), .BLINK_DIV(4)) uut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.panel_enable, .cursor_visible, .cursor_addr, .view_offset);

	clie_host host (
		.aclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
		.wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
		.bready(s_axi_bready), .bvalid(s_axi_bvalid), .araddr(s_axi_araddr), .arvalid(s_axi_arvalid),
		.arready(s_axi_arready), .rready(s_axi_rready), .rvalid(s_axi_rvalid), .rdata(s_axi_rdata));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cmp(input logic [31:0] v);
		logic [31:0] e;
		logic [31:0] m;
		e = host.exp_q.pop_front();
		m = host.msk_q.pop_front();
		check(v & m, e & m);
	endtask

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// registered outputs land a cycle or two after the command edge
	task automatic settle();
		repeat (2) @(posedge aclk);
		#1;
	endtask

	task automatic mode(input logic [9:0] e, input logic [9:0] m);
		host.bus_rd(OFS_MODE, {22'h0, e}, {22'h3fffff, m}, d);
	endtask

	always @(posedge aclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			cmp({s_axi_bresp, 30'h0});
		if (s_axi_rvalid && s_axi_rready)
			cmp({s_axi_rresp, s_axi_rdata[29:0]});
	end

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			failures++;
			test_done();
		end
	end

	initial
	begin
		void'($urandom(32'h3cf36ace));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		check({25'h0, view_offset}, 32'h0);
		mode(10'h021, 10'h3ff);
		host.bus_wr(OFS_STATUS, 8'h00, RESP_SLVERR);
		host.bus_wr(OFS_MODE, 8'h00, RESP_SLVERR);
		host.bus_rd(OFS_CMD, {RESP_SLVERR, 30'h0}, 32'hc0000000, d);
		$display("test reset finished");
		host.put(1'b0, 8'h01);
		host.put(1'b0, 8'h38);
		host.put(1'b0, 8'h0c);
		settle();
		check({31'h0, panel_enable}, 32'h1);
		check({31'h0, cursor_visible}, 32'h0);
		mode(10'h060, 10'h060);
		rb = 8'($urandom);
		host.put(1'b0, 8'ha7);
		host.put(1'b1, rb);
		host.get(1'b0, 8'h40, 8'hff);
		check({25'h0, cursor_addr}, 32'h40);
		host.put(1'b0, 8'he7);
		host.put(1'b1, rb);
		host.get(1'b0, 8'h00, 8'hff);
		host.put(1'b0, 8'ha7);
		host.get(1'b1, rb, 8'hff);
		rc = 8'($urandom);
		host.put(1'b0, 8'h90);
		host.put(1'b1, rc);
		host.get(1'b0, 8'h11, 8'hff);
		host.get(1'b1, 8'h00, 8'h00);
		host.put(1'b0, 8'h90);
		host.get(1'b1, rc, 8'hff);
		$display("test text writes finished");
		host.put(1'b0, 8'h04);
		host.put(1'b0, 8'h80);
		host.put(1'b1, rb);
		host.get(1'b0, 8'h67, 8'hff);
		mode(10'h000, 10'h001);
		host.put(1'b0, 8'h07);
		host.put(1'b0, 8'h80);
		host.put(1'b1, rb);
		settle();
		check({25'h0, view_offset}, 32'h1);
		host.get(1'b1, 8'h00, 8'h00);
		host.put(1'b0, 8'h40);
		host.put(1'b1, rb);
		settle();
		check({25'h0, view_offset}, 32'h1);
		host.put(1'b0, 8'h05);
		host.put(1'b0, 8'h80);
		host.put(1'b1, rb);
		settle();
		check({25'h0, view_offset}, 32'h0);
		host.put(1'b0, 8'h06);
		$display("test entry modes finished");
		host.put(1'b0, 8'h90);
		for (int i = 0; i < 4; i++)
		begin
			host.put(1'b0, 8'h10 | 8'(i << 2));
			host.get(1'b0, (i == 0) ? 8'h0f : 8'h10, 8'hff);
			settle();
			check({25'h0, view_offset}, (i == 2) ? 32'h1 : 32'h0);
		end
		host.put(1'b1, 8'h5a);
		host.put(1'b0, 8'h10);
		host.get(1'b1, 8'h5a, 8'hff);
		host.put(1'b0, 8'h18);
		host.put(1'b0, 8'h02);
		host.get(1'b0, 8'h00, 8'hff);
		settle();
		check({25'h0, view_offset}, 32'h0);
		host.put(1'b0, 8'h90);
		host.get(1'b1, 8'h5a, 8'hff);
		host.put(1'b0, 8'h7f);
		mode(10'h100, 10'h100);
		host.put(1'b1, rc);
		host.get(1'b0, 8'h00, 8'hff);
		host.put(1'b0, 8'h7f);
		host.get(1'b1, rc, 8'hff);
		host.get(1'b1, rb, 8'hff);
		$display("test shifts finished");
		host.put(1'b0, 8'h04);
		host.put(1'b0, 8'h01);
		host.get(1'b0, 8'h00, 8'hff);
		mode(10'h001, 10'h101);
		host.put(1'b0, 8'h90);
		host.get(1'b1, 8'h20, 8'hff);
		host.put(1'b0, 8'h08);
		settle();
		check({31'h0, panel_enable}, 32'h0);
		host.put(1'b0, 8'h0e);
		settle();
		check({31'h0, panel_enable}, 32'h1);
		check({31'h0, cursor_visible}, 32'h1);
		mode(10'h001, 10'h001);
		host.put(1'b0, 8'h0d);
		saw = 2'b00;
		repeat (100)
		begin
			@(negedge aclk);
			saw = saw | {cursor_visible === 1'b1, cursor_visible === 1'b0};
		end
		check({30'h0, saw}, 32'h3);
		host.put(1'b0, 8'h0c);
		settle();
		check({31'h0, cursor_visible}, 32'h0);
		host.put(1'b0, 8'h85);
		host.bus_rd(OFS_STATUS, 32'h85, 32'hffffffff, d);
		host.bus_wr(OFS_CMD, 8'h91, RESP_OKAY);
		repeat (880) @(posedge aclk);
		host.bus_rd(OFS_STATUS, 32'h80, 32'h80, d);
		host.get(1'b0, 8'h05, 8'hff);
		$display("test clear and display finished");
		host.put(1'b0, 8'h28);
		mode(10'h040, 10'h060);
		rb = 8'($urandom);
		host.put(1'b0, 8'h85);
		host.put(1'b1, rb);
		host.put(1'b0, 8'h85);
		host.get(1'b1, rb, 8'hff);
		host.get(1'b0, 8'h06, 8'hff);
		host.put(1'b0, 8'h2c);
		mode(10'h080, 10'h080);
		host.put(1'b0, 8'h20);
		mode(10'h000, 10'h0c0);
		host.put(1'b0, 8'hcf);
		host.put(1'b1, rb);
		host.get(1'b0, 8'h00, 8'hff);
		host.put(1'b0, 8'h30);
		mode(10'h020, 10'h020);
		$display("test nibble bus finished");
		test_done();
	end
endmodule
`default_nettype wire

// ### clie_host.sv
// Purpose: host processor model driving the display engine over AXI4-Lite
// Assumes: one write or one read under way at a time
// Notes: every expected answer is noted in exp_q/msk_q for the bench monitor
`timescale 1ns/1ps
`default_nettype none
module clie_host
	import clie_pkg::*;
(
	input  wire logic        aclk,
	output logic [3:0]       awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	output logic             bready,
	input  wire logic        bvalid,
	output logic [3:0]       araddr,
	output logic             arvalid,
	input  wire logic        arready,
	output logic             rready,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata
);
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic        nib = 1'b0;

	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] b, input logic [1:0] er);
		logic [1:0] took;
		took = 2'b00;
		exp_q.push_back({er, 30'h0});
		msk_q.push_back(32'hffffffff);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, b};
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (took != 2'b11)
		begin
			@(posedge aclk);
			if (awready === 1'b1)
			begin
				took[1] = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				took[0] = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic bus_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] q);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		q = rdata;
		rready <= 1'b0;
	endtask

	task automatic rd8(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, output logic [7:0] q);
		logic [31:0] x;
		if (nib)
		begin
			bus_rd(a, {24'h0, e[7:4], 4'h0}, {24'hffffff, m[7:4], 4'h0}, x);
			q[7:4] = x[7:4];
			bus_rd(a, {24'h0, e[3:0], 4'h0}, {24'hffffff, m[3:0], 4'h0}, x);
			q[3:0] = x[7:4];
		end
		else
		begin
			bus_rd(a, {24'h0, e}, {24'hffffff, m}, x);
			q = x[7:0];
		end
	endtask

	task automatic idle();
		logic [7:0] s;
		do rd8(OFS_STATUS, 8'h00, 8'h00, s); while (s[7] !== 1'b0);
	endtask

	task automatic put(input logic rs, input logic [7:0] b);
		logic [3:0] a;
		a = rs ? OFS_DATA : OFS_CMD;
		idle();
		if (nib)
		begin
			bus_wr(a, {b[7:4], 4'h0}, RESP_OKAY);
			bus_wr(a, {b[3:0], 4'h0}, RESP_OKAY);
		end
		else
			bus_wr(a, b, RESP_OKAY);
		if (!rs && b[7:5] == 3'b001)
			nib = !b[4];
	endtask

	// stale reads get a zero mask
	task automatic get(input logic rs, input logic [7:0] e, input logic [7:0] m);
		logic [7:0] q;
		idle();
		rd8(rs ? OFS_DATA : OFS_STATUS, e, m, q);
	endtask
endmodule
`default_nettype wire

// ### clie_pkg.sv
// Purpose: constants and carriers for the character display instruction engine
// Assumes: 25 MHz aclk, AXI4-Lite register access
// Notes: timing counts derive from the printed execution times
package clie_pkg;
	localparam int unsigned CLK_HZ        = 25000000;
	localparam int unsigned LONG_EXEC_NS  = 1530000;
	localparam int unsigned CMD_EXEC_NS   = 39000;
	localparam int unsigned DATA_EXEC_NS  = 43000;
	localparam int unsigned CLK_NS        = 1000000000 / CLK_HZ;
	localparam int unsigned LONG_CYC      = (LONG_EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CMD_CYC       = (CMD_EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DATA_CYC      = (DATA_EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TEXT_DEPTH    = 128;
	localparam int unsigned GLYPH_DEPTH   = 64;
	localparam logic [7:0]  SPACE_CODE    = 8'h20;
	localparam logic [6:0]  ADDR_HOME     = 7'h00;
	localparam logic [6:0]  ONE_LINE_LAST = 7'h4f;
	localparam logic [6:0]  LINE1_LAST    = 7'h27;
	localparam logic [6:0]  LINE2_FIRST   = 7'h40;
	localparam logic [6:0]  LINE2_LAST    = 7'h67;
	localparam logic [6:0]  SHIFT_WRAP    = 7'h28;
	localparam logic [6:0]  SHIFT_WRAP1   = 7'h50;
	// register byte offsets
	localparam logic [3:0]  OFS_CMD       = 4'h0;
	localparam logic [3:0]  OFS_DATA      = 4'h4;
	localparam logic [3:0]  OFS_STATUS    = 4'h8;
	localparam logic [3:0]  OFS_MODE      = 4'hc;
	// field positions of the mode register
	localparam int unsigned MB_INC        = 0;
	localparam int unsigned MB_SHE        = 1;
	localparam int unsigned MB_DISP       = 2;
	localparam int unsigned MB_CUR        = 3;
	localparam int unsigned MB_BLINK      = 4;
	localparam int unsigned MB_WIDE       = 5;
	localparam int unsigned MB_TWO        = 6;
	localparam int unsigned MB_TALL       = 7;
	localparam int unsigned MB_GLYPH      = 8;
	localparam int unsigned MB_NIB        = 9;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	typedef struct packed {
		logic       inc;
		logic       shift_entry;
		logic       disp_on;
		logic       cursor_on;
		logic       blink_on;
		logic       wide_bus;
		logic       two_line;
		logic       tall_font;
	} clie_mode_t;

	typedef enum logic [1:0] {
		CLIE_IDLE  = 2'b00,
		CLIE_EXEC  = 2'b01,
		CLIE_CLEAR = 2'b11
	} clie_state_t;
endpackage
